// ===== ssp_top.sv
// The AXI4-Lite interface to the registers was decided locally.
`default_nettype none
// Notes on behaviour
// (R1) External clock: shift starting with empty transmit buffer is a transmit error.
// (R2) Underrun flag sets at shift start; interrupt still follows all eight bits.
// (R3) First shift after run set with nothing written also flags underrun.
// (R4) Serial out pin held high while underrun flag is set.
// (R5) Software reads receive buffer, then forces stop, after a transmit error.
// (R6) Force stop halts at once, clears run, status and both buffers.
// (R7) Force stop bit clears itself after the stop; writing zero does nothing.
// (R8) External clock: frame end while receive full still set flags overrun.
// (R9) While overrun is set incoming data is discarded; buffer and shifter frozen.
// (R10) Software recovers overrun by clearing run, then reading receive buffer.
// (R11) Second receive buffer read after overrun returns the shift register.
// (R12) Clearing overrun after data was read also clears receive full.
// (R13) Run cleared with external clock: stops after eight more clock pulses.
// (R14) Software waits for transfer active to drop before restarting.
// (R15) Software may force stop to end reception after overrun.
// (R16) Software sets pin output latches to one before serial use.
// (R17) Mode 00 transmit, 01 receive, 10 both, 11 reserved.
// (R18) Bit order zero sends bit 7 first, one sends bit 0 first.
// (R19) Clock codes 000-110 pick divided internal clocks; 111 external pin.
// (R20) Software changes mode, order, clock only while transfer inactive.
// (R21) Activity and error state readable in a status register.
// (R22) Error flags survive run clear; cleared by writing zero or force stop.
// (R23) Transmit shifts on falling clock edge, receive samples on rising edge.
// (R24) Internal clock: serial clock pin high before and after transfers.
// (R25) Low-frequency mode uses code 000 only; other internal codes reserved. Here the slow bit selects it for every internal code.
module ssp_top
    import ssp_pkg::*;
#(
    parameter int FS_DIV = SSP_FS_DIV
) (
    input wire logic i_clk, // 10 MHz system clock
    input wire logic i_reset_n, // Async reset, active low
    input wire logic i_awvalid, // AXI write address valid
    input wire logic [SSP_ADDR_W-1:0] i_awaddr, // AXI write address
    output logic o_awready, // AXI write address ready
    input wire logic i_wvalid, // AXI write data valid
    input wire logic [SSP_DATA_W-1:0] i_wdata, // AXI write data
    input wire logic [3:0] i_wstrb, // AXI write strobes
    output logic o_wready, // AXI write data ready
    output logic o_bvalid, // AXI write response valid
    output logic [1:0] o_bresp, // AXI write response
    input wire logic i_bready, // AXI write response ready
    input wire logic i_arvalid, // AXI read address valid
    input wire logic [SSP_ADDR_W-1:0] i_araddr, // AXI read address
    output logic o_arready, // AXI read address ready
    output logic o_rvalid, // AXI read data valid
    output logic [SSP_DATA_W-1:0] o_rdata, // AXI read data
    output logic [1:0] o_rresp, // AXI read response
    input wire logic i_rready, // AXI read data ready
    input wire logic i_serial_in_pin, // Serial data in
    output logic o_serial_out_pin, // Serial data out
    input wire logic i_serial_clock_pin, // Serial clock pin level
    output logic o_serial_clock_pin, // Serial clock drive value
    output logic o_serial_clock_oe_n, // Low while clock is driven
    output logic o_serial_irq // One-cycle frame-done pulse
);
    localparam int FS_W = $clog2(FS_DIV);
    if (FS_DIV < 2) begin : g_bad_div
        $error("FS_DIV must be at least 2");
    end

    // ======================================================
    // AXI4-Lite slave
    logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
    logic aw_full_r, w_full_r;
    logic [1:0] bresp_r, rresp_r;
    logic [SSP_ADDR_W-1:0] awaddr_r;
    logic [7:0] wdata_r;
    logic wstrb0_r;
    logic [SSP_DATA_W-1:0] rdata_r;
    logic wr_do, ar_hs;
    logic [7:0] wr_idx, rd_idx;
    logic wr_ctrl, wr_stat, wr_tx, wr_tb, rd_rx;
    logic [7:0] rd_val;
    logic rd_hit;

    assign wr_do = aw_full_r && w_full_r && !bvalid_r;
    assign ar_hs = i_arvalid && arready_r;
    assign wr_idx = awaddr_r[9:2];
    assign rd_idx = i_araddr[9:2];
    assign wr_ctrl = wr_do && wstrb0_r && wr_idx == SSP_IDX_CTRL;
    assign wr_stat = wr_do && wstrb0_r && wr_idx == SSP_IDX_STATUS;
    assign wr_tx = wr_do && wstrb0_r && wr_idx == SSP_IDX_TXBUF;
    assign wr_tb = wr_do && wstrb0_r && wr_idx == SSP_IDX_TBASE;
    assign rd_rx = ar_hs && rd_idx == SSP_IDX_RXBUF;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            awready_r <= 1'b1;
            wready_r <= 1'b1;
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= SSP_RESP_OKAY;
            awaddr_r <= '0;
            wdata_r <= 8'h00;
            wstrb0_r <= 1'b0;
        end else begin
            if (i_awvalid && awready_r) begin
                awready_r <= 1'b0;
                aw_full_r <= 1'b1;
                awaddr_r <= i_awaddr;
            end
            if (i_wvalid && wready_r) begin
                wready_r <= 1'b0;
                w_full_r <= 1'b1;
                wdata_r <= i_wdata[7:0];
                wstrb0_r <= i_wstrb[0];
            end
            if (wr_do) begin
                aw_full_r <= 1'b0;
                w_full_r <= 1'b0;
                bvalid_r <= 1'b1;
                bresp_r <= (wr_idx >= SSP_IDX_CTRL && wr_idx <= SSP_IDX_TBASE)
                    ? SSP_RESP_OKAY : SSP_RESP_SLVERR;
            end
            if (bvalid_r && i_bready) begin
                bvalid_r <= 1'b0;
                awready_r <= 1'b1;
                wready_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            arready_r <= 1'b1;
            rvalid_r <= 1'b0;
            rdata_r <= '0;
            rresp_r <= SSP_RESP_OKAY;
        end else begin
            if (ar_hs) begin
                arready_r <= 1'b0;
                rvalid_r <= 1'b1;
                rdata_r <= {24'h000000, rd_val};
                rresp_r <= rd_hit ? SSP_RESP_OKAY : SSP_RESP_SLVERR;
            end else if (rvalid_r && i_rready) begin
                rvalid_r <= 1'b0;
                arready_r <= 1'b1;
            end
        end
    end

    // ======================================================
    // Control and time base registers
    ssp_ctrl_t ctrl_r;
    logic tb_div7_r, tb_slow_r;
    logic force_now;
    logic ext;
    assign force_now = wr_ctrl && wdata_r[6];
    assign ext = ctrl_r.clk_sel == SSP_SCK_EXT;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            ctrl_r <= ssp_ctrl_t'(SSP_CTRL_RESET);
            tb_div7_r <= 1'b0;
            tb_slow_r <= 1'b0;
        end else begin
            // Stop bit reads back one only for the cycle after the write
            ctrl_r.force_stop <= 1'b0; // see (R7)
            if (wr_ctrl) begin
                ctrl_r <= ssp_ctrl_t'(wdata_r);
                if (force_now) begin
                    ctrl_r.run <= 1'b0; // see (R6)
                end
            end
            if (wr_tb) begin
                tb_div7_r <= wdata_r[SSP_TB_DIV7];
                tb_slow_r <= wdata_r[SSP_TB_SLOW];
            end
        end
    end

    // ======================================================
    // Internal serial clock dividers
    logic [11:0] div_cnt_r;
    logic [FS_W-1:0] fs_pre_r;
    logic [2:0] fs_cnt_r;
    logic use_fs, fs_tick, int_tick;
    logic [3:0] half_exp;
    logic [11:0] half_mask;

    // Slow mode forces the low-frequency source for every internal code
    assign use_fs = tb_slow_r || (ctrl_r.clk_sel == 3'h0 && tb_div7_r); // see (R25)
    assign half_exp = (ctrl_r.clk_sel == 3'h0) ? SSP_FC_SLOW_HALF_EXP
        : SSP_FC_HALF_BASE - {1'b0, ctrl_r.clk_sel}; // see (R19)
    assign half_mask = ~(12'hFFF << half_exp);
    assign fs_tick = fs_pre_r == FS_W'(FS_DIV - 1);
    assign int_tick = use_fs ? (fs_tick && fs_cnt_r == SSP_FS_HALF_TICKS)
        : ((div_cnt_r & half_mask) == half_mask);

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            div_cnt_r <= 12'h000;
            fs_pre_r <= '0;
            fs_cnt_r <= 3'h0;
        end else begin
            div_cnt_r <= div_cnt_r + 12'h001;
            fs_pre_r <= fs_tick ? '0 : fs_pre_r + FS_W'(1);
            if (fs_tick) begin
                fs_cnt_r <= fs_cnt_r + 3'h1;
            end
        end
    end

    // ======================================================
    // Pin synchronisers
    logic sck_s1_r, sck_s2_r, sck_s3_r, si_s1_r, si_s2_r;
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sck_s1_r <= 1'b1;
            sck_s2_r <= 1'b1;
            sck_s3_r <= 1'b1;
            si_s1_r <= 1'b1;
            si_s2_r <= 1'b1;
        end else begin
            sck_s1_r <= i_serial_clock_pin;
            sck_s2_r <= sck_s1_r;
            sck_s3_r <= sck_s2_r;
            si_s1_r <= i_serial_in_pin;
            si_s2_r <= si_s1_r;
        end
    end

    // ======================================================
    // Shift engine
    logic [7:0] txbuf_r, rxbuf_r, txsh_r, rxsh_r, tx_cur, rx_next;
    logic tx_empty_r, rx_full_r, tx_err_r, rx_err_r, ovr_read_r;
    logic active_r, shifting_r, sck_r, so_r, irq_r, sck_oe_n_r;
    logic [3:0] bitcnt_r;
    logic has_tx, has_rx, start_ok, fall, rise, start, done, underrun;

    assign has_tx = ctrl_r.mode == SSP_MODE_TX
        || ctrl_r.mode == SSP_MODE_TRX; // see (R17)
    assign has_rx = ctrl_r.mode == SSP_MODE_RX
        || ctrl_r.mode == SSP_MODE_TRX;
    // Internal clock waits for data; external clock cannot be held off
    assign start_ok = ext ? ((ctrl_r.run || active_r) // see (R13)
            && ctrl_r.mode != SSP_MODE_RSVD)
        : (ctrl_r.run && ctrl_r.mode != SSP_MODE_RSVD
            && !(has_tx && tx_empty_r) && !(has_rx && rx_full_r));
    assign fall = (ext ? (sck_s3_r && !sck_s2_r) : (int_tick && sck_r))
        && (bitcnt_r != 4'h0 || start_ok) && bitcnt_r != SSP_FRAME_BITS;
    assign rise = (ext ? (!sck_s3_r && sck_s2_r) : (int_tick && !sck_r))
        && bitcnt_r != 4'h0;
    assign start = fall && bitcnt_r == 4'h0;
    assign done = rise && bitcnt_r == SSP_FRAME_BITS;
    assign underrun = start && ext && has_tx && tx_empty_r; // see (R1) (R3)
    assign tx_cur = (bitcnt_r == 4'h0) ? txbuf_r : txsh_r;
    assign rx_next = ctrl_r.lsb_first ? {si_s2_r, rxsh_r[7:1]}
        : {rxsh_r[6:0], si_s2_r}; // see (R18)

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            txbuf_r <= 8'h00;
            rxbuf_r <= 8'h00;
            txsh_r <= 8'h00;
            rxsh_r <= 8'h00;
            tx_empty_r <= SSP_STATUS_RESET[SSP_ST_TXE];
            rx_full_r <= 1'b0;
            tx_err_r <= 1'b0;
            rx_err_r <= 1'b0;
            ovr_read_r <= 1'b0;
            active_r <= 1'b0;
            shifting_r <= 1'b0;
            bitcnt_r <= 4'h0;
            sck_r <= 1'b1;
            so_r <= 1'b1;
            irq_r <= 1'b0;
        end else if (force_now) begin // see (R6)
            txbuf_r <= 8'h00;
            rxbuf_r <= 8'h00;
            tx_empty_r <= SSP_STATUS_RESET[SSP_ST_TXE];
            rx_full_r <= 1'b0;
            tx_err_r <= 1'b0; // see (R22)
            rx_err_r <= 1'b0;
            ovr_read_r <= 1'b0;
            active_r <= 1'b0;
            shifting_r <= 1'b0;
            bitcnt_r <= 4'h0;
            sck_r <= 1'b1;
            so_r <= 1'b1;
            irq_r <= 1'b0;
        end else begin
            irq_r <= 1'b0;
            // Software clears first so a same-cycle hardware set wins
            if (wr_tx && tx_empty_r) begin
                txbuf_r <= wdata_r;
                tx_empty_r <= 1'b0;
            end
            if (rd_rx) begin
                if (rx_err_r) begin
                    ovr_read_r <= 1'b1; // see (R11)
                end else begin
                    rx_full_r <= 1'b0;
                end
            end
            if (wr_stat && !wdata_r[SSP_ST_TX_UNDERRUN_FLAG]) begin
                tx_err_r <= 1'b0; // see (R22)
            end
            if (wr_stat && !wdata_r[SSP_ST_RX_OVERRUN_FLAG]) begin
                rx_err_r <= 1'b0;
                ovr_read_r <= 1'b0;
                if (ovr_read_r) begin
                    rx_full_r <= 1'b0; // see (R12)
                end
            end
            if (fall) begin // see (R23)
                sck_r <= ext ? sck_r : 1'b0;
                bitcnt_r <= bitcnt_r + 4'h1;
                shifting_r <= bitcnt_r != 4'h7;
                txsh_r <= ctrl_r.lsb_first ? {1'b1, tx_cur[7:1]}
                    : {tx_cur[6:0], 1'b1};
                so_r <= (!has_tx || tx_err_r || underrun) ? 1'b1
                    : (ctrl_r.lsb_first ? tx_cur[0] : tx_cur[7]); // see (R4)
                if (start) begin
                    active_r <= 1'b1;
                    if (has_tx && !tx_empty_r) begin
                        tx_empty_r <= 1'b1;
                    end
                end
                if (underrun) begin
                    tx_err_r <= 1'b1; // see (R1) (R2)
                end
            end
            if (rise) begin
                sck_r <= 1'b1; // see (R24)
                if (has_rx && !rx_err_r) begin
                    rxsh_r <= rx_next; // see (R9)
                end
            end
            if (done) begin
                bitcnt_r <= 4'h0;
                active_r <= ctrl_r.run;
                // An uncorrected overrun silences further frame interrupts
                irq_r <= !rx_err_r; // see (R2)
                if (has_rx && !rx_err_r) begin
                    if (rx_full_r && ext) begin
                        rx_err_r <= 1'b1; // see (R8)
                    end else begin
                        rxbuf_r <= rx_next;
                        rx_full_r <= 1'b1;
                    end
                end
            end
        end
    end

    // Clock pin is released to the outside when the external source is set
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sck_oe_n_r <= 1'b1;
        end else begin
            sck_oe_n_r <= ext; // see (R19)
        end
    end

    // ======================================================
    // Register read mux
    always_comb begin
        rd_val = 8'h00;
        rd_hit = 1'b1;
        unique case (rd_idx)
            SSP_IDX_CTRL: rd_val = ctrl_r;
            SSP_IDX_STATUS: rd_val = {active_r, shifting_r, tx_empty_r,
                rx_full_r, tx_err_r, rx_err_r, 2'b00}; // see (R21)
            SSP_IDX_TXBUF: rd_val = 8'h00;
            SSP_IDX_RXBUF: rd_val = (rx_err_r && ovr_read_r) ? rxsh_r
                : rxbuf_r; // see (R11)
            SSP_IDX_TBASE: rd_val = {6'h00, tb_slow_r, tb_div7_r};
            default: rd_hit = 1'b0;
        endcase
    end

    assign o_awready = awready_r;
    assign o_wready = wready_r;
    assign o_bvalid = bvalid_r;
    assign o_bresp = bresp_r;
    assign o_arready = arready_r;
    assign o_rvalid = rvalid_r;
    assign o_rdata = rdata_r;
    assign o_rresp = rresp_r;
    assign o_serial_out_pin = so_r;
    assign o_serial_clock_pin = sck_r;
    assign o_serial_clock_oe_n = sck_oe_n_r;
    assign o_serial_irq = irq_r;

    // ======================================================
    // Assertions
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    a_underrun_flag_set: assert property ( // see (R1)
        underrun && !force_now |=> tx_err_r ##0 so_r)
        else $error("underrun not flagged at shift start");
    a_so_held_high: assert property ( // see (R4)
        tx_err_r |-> o_serial_out_pin)
        else $error("serial out low during underrun");
    a_irq_after_frame: assert property ( // see (R2)
        done && !rx_err_r && !force_now |=> o_serial_irq ##1 !o_serial_irq)
        else $error("frame interrupt missing or long");
    a_force_clears_all: assert property ( // see (R6)
        force_now |=> !ctrl_r.run && !active_r && tx_empty_r && !rx_full_r
            && !tx_err_r && !rx_err_r && rxbuf_r == 8'h00)
        else $error("force stop left state behind");
    a_force_self_clear: assert property ( // see (R7)
        ctrl_r.force_stop |=> !ctrl_r.force_stop)
        else $error("force stop bit stuck");
    a_overrun_flag_set: assert property ( // see (R8)
        done && ext && has_rx && rx_full_r && !rx_err_r && !force_now
            |=> rx_err_r && $stable(rxbuf_r))
        else $error("overrun not flagged");
    a_overrun_frozen: assert property ( // see (R9)
        rx_err_r && !force_now |=> $stable(rxbuf_r) && $stable(rxsh_r))
        else $error("receive data changed during overrun");
    a_sck_idle_high: assert property ( // see (R24)
        !ext && bitcnt_r == 4'h0 |-> o_serial_clock_pin)
        else $error("internal clock not high while idle");
    a_shift_inside_active: assert property ( // see (R21)
        shifting_r |-> active_r && bitcnt_r != 4'h0)
        else $error("shift flag outside active transfer");
endmodule : ssp_top
`default_nettype wire

// ===== ssp_pkg.sv
`default_nettype none
package ssp_pkg;
    // ======================================================
    // Register map (word indices, byte address = 4 * index)
    localparam logic [7:0] SSP_IDX_CTRL = 8'h31;
    localparam logic [7:0] SSP_IDX_STATUS = 8'h32;
    localparam logic [7:0] SSP_IDX_TXBUF = 8'h33;
    localparam logic [7:0] SSP_IDX_RXBUF = 8'h34;
    localparam logic [7:0] SSP_IDX_TBASE = 8'h35;
    localparam int SSP_ADDR_W = 12;
    localparam int SSP_DATA_W = 32;
    localparam logic [7:0] SSP_CTRL_RESET = 8'h00;
    localparam logic [7:0] SSP_STATUS_RESET = 8'h20;
    localparam logic [1:0] SSP_RESP_OKAY = 2'h0;
    localparam logic [1:0] SSP_RESP_SLVERR = 2'h2;
    // ======================================================
    // Status bit positions
    localparam int SSP_ST_ACTIVE = 7;
    localparam int SSP_ST_SHIFT = 6;
    localparam int SSP_ST_TXE = 5;
    localparam int SSP_ST_RXF = 4;
    localparam int SSP_ST_TX_UNDERRUN_FLAG = 3;
    localparam int SSP_ST_RX_OVERRUN_FLAG = 2;
    // Time base register bit positions
    localparam int SSP_TB_DIV7 = 0;
    localparam int SSP_TB_SLOW = 1;
    // ======================================================
    // Serial clock and frame timing
    localparam logic [2:0] SSP_SCK_EXT = 3'h7;
    localparam logic [3:0] SSP_FC_SLOW_HALF_EXP = 4'hB;
    localparam logic [3:0] SSP_FC_HALF_BASE = 4'h8;
    localparam logic [2:0] SSP_FS_HALF_TICKS = 3'h7;
    localparam logic [3:0] SSP_FRAME_BITS = 4'h8;
    localparam int SSP_FC_HZ = 10_000_000;
    localparam int SSP_FS_HZ = 32_768;
    localparam int SSP_FS_DIV = SSP_FC_HZ / SSP_FS_HZ;
    // ======================================================
    // Types
    typedef enum logic [1:0] {
        SSP_MODE_TX = 2'h0,
        SSP_MODE_RX = 2'h1,
        SSP_MODE_TRX = 2'h2,
        SSP_MODE_RSVD = 2'h3
    } ssp_mode_t;
    typedef struct packed {
        logic run;
        logic force_stop;
        ssp_mode_t mode;
        logic lsb_first;
        logic [2:0] clk_sel;
    } ssp_ctrl_t;
endpackage : ssp_pkg
`default_nettype wire

// ===== ssp_ext_dev.sv
`default_nettype none
module ssp_ext_dev #(
    parameter int HALF = 8
) (
    input wire logic i_clk, // System clock
    input wire logic i_rst_n, // Bench reset, active low
    input wire logic i_go, // Start one frame
    input wire logic [7:0] i_byte, // Byte to send
    input wire logic i_lsb, // Send bit 0 first
    input wire logic i_sck, // Clock wire level
    input wire logic i_so, // Device serial out
    output logic o_sck, // Driven clock, idle high
    output logic o_si, // Data into device
    output logic [7:0] o_got, // Last byte captured
    output logic o_busy // Frame in progress
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] sh;
    int n;
    initial begin
        o_sck = 1'b1;
        o_si = 1'b1;
        o_got = 8'h00;
        o_busy = 1'b0;
        sh = 8'h00;
        n = 0;
    end
    // ======
    // Clock stands high between frames
    always begin
        @(posedge i_clk);
        if (i_go) begin
            o_busy <= 1'b1;
            for (int b = 0; b < 8; b++) begin
                o_sck <= 1'b0;
                o_si <= i_lsb ? i_byte[b] : i_byte[7-b];
                repeat (HALF) @(posedge i_clk);
                o_sck <= 1'b1;
                repeat (HALF) @(posedge i_clk);
            end
            // Released line flips so a stale bit is never trusted
            o_si <= ~o_si;
            o_busy <= 1'b0;
        end
    end
    always @(posedge i_sck) begin
        // The wire settles from unknown to high in reset; not a clock pulse
        if (i_rst_n) begin
            sh = {sh[6:0], i_so};
            n = (n + 1) % 8;
            if (n == 0) o_got <= sh;
        end
    end
endmodule : ssp_ext_dev
`default_nettype wire

// ===== ssp_tb_top.sv
`default_nettype none
module ssp_tb_top
    import ssp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic awv = 1'b0;
    logic wv = 1'b0;
    logic brdy = 1'b0;
    logic arv = 1'b0;
    logic rrdy = 1'b0;
    logic [SSP_ADDR_W-1:0] awa = '0;
    logic [SSP_ADDR_W-1:0] ara = '0;
    logic [31:0] wd = 32'h0;
    logic go = 1'b0;
    logic lsb = 1'b0;
    logic [7:0] txb = 8'h00;
    logic awr, wr_rdy, bv, arr, rv, so, sck_drv, oe_n, irq;
    logic dev_sck, si, busy;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, v;
    logic [7:0] got;
    // Whoever enables drives the shared clock wire
    wire logic sck_w = oe_n ? dev_sck : sck_drv;
    int miscompares = 0;
    int n_checks = 0;
    int irqs = 0;
    int n0;
    always #50 clk = ~clk;
    always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;
    ssp_top #(.FS_DIV(2)) u_ssp_top (
        .i_clk(clk), .i_reset_n(rst_n),
        .i_awvalid(awv), .i_awaddr(awa), .o_awready(awr),
        .i_wvalid(wv), .i_wdata(wd), .i_wstrb(4'hF), .o_wready(wr_rdy),
        .o_bvalid(bv), .o_bresp(bresp), .i_bready(brdy),
        .i_arvalid(arv), .i_araddr(ara), .o_arready(arr),
        .o_rvalid(rv), .o_rdata(rdata), .o_rresp(rresp), .i_rready(rrdy),
        .i_serial_in_pin(si), .o_serial_out_pin(so),
        .i_serial_clock_pin(sck_w), .o_serial_clock_pin(sck_drv),
        .o_serial_clock_oe_n(oe_n), .o_serial_irq(irq)
    );
    ssp_ext_dev u_ssp_ext_dev (
        .i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_byte(txb), .i_lsb(lsb),
        .i_sck(sck_w),
        .i_so(so), .o_sck(dev_sck), .o_si(si), .o_got(got), .o_busy(busy)
    );
    // ======
    // Tasks
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk);
        awa <= SSP_ADDR_W'({idx, 2'b00});
        wd <= {24'h000000, d};
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        // Only the watchdog ends a wait for the response
        do begin
            @(posedge clk);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr_rdy) wv <= 1'b0;
        end while (!bv);
        rs = bresp;
        brdy <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] idx);
        @(posedge clk);
        ara <= SSP_ADDR_W'({idx, 2'b00});
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(posedge clk);
            if (arv && arr) arv <= 1'b0;
        end while (!rv);
        v = rdata;
        rs = rresp;
        rrdy <= 1'b0;
    endtask : rd
    task automatic rdc(input logic [7:0] idx, input logic [7:0] m,
                       input logic [7:0] e);
        rd(idx);
        chk(v & {24'h0, m}, {24'h0, e});
        chk(32'(rs), 32'(SSP_RESP_OKAY));
    endtask : rdc
    task automatic frame(input logic [7:0] b, input logic l);
        int t;
        t = 0;
        @(posedge clk);
        go <= 1'b1;
        txb <= b;
        lsb <= l;
        @(posedge clk);
        go <= 1'b0;
        repeat (2) @(posedge clk);
        while (busy && t < 1000) begin
            @(posedge clk);
            t++;
        end
        repeat (8) @(posedge clk);
    endtask : frame
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : give_verdict
    // ======
    // Tests
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        rdc(SSP_IDX_CTRL, 8'hFF, 8'h00);
        rdc(SSP_IDX_STATUS, 8'hFC, 8'h20);
        rd(8'h3F);
        chk(32'(rs), 32'(SSP_RESP_SLVERR));
        chk(v, 32'h0);
        $display("test reset done");
        wr(SSP_IDX_TXBUF, 8'hA5);
        chk(32'(rs), 32'(SSP_RESP_OKAY));
        wr(8'h3F, 8'h00);
        chk(32'(rs), 32'(SSP_RESP_SLVERR));
        wr(SSP_IDX_CTRL, 8'hA7);
        // Clock enable follows the control write by one register stage
        @(posedge clk);
        chk(32'(oe_n), 32'h1);
        n0 = irqs;
        frame(8'h3C, 1'b0);
        chk(32'(got), 32'hA5);
        chk(irqs, n0 + 1);
        rdc(SSP_IDX_STATUS, 8'h3C, 8'h30);
        rdc(SSP_IDX_RXBUF, 8'hFF, 8'h3C);
        n0 = irqs;
        frame(8'hC3, 1'b0);
        rdc(SSP_IDX_STATUS, 8'h08, 8'h08);
        chk(32'(got), 32'hFF);
        chk(irqs, n0 + 1);
        rdc(SSP_IDX_RXBUF, 8'hFF, 8'hC3);
        wr(SSP_IDX_CTRL, 8'h40);
        rdc(SSP_IDX_CTRL, 8'hFF, 8'h00);
        rdc(SSP_IDX_STATUS, 8'hFC, 8'h20);
        rdc(SSP_IDX_RXBUF, 8'hFF, 8'h00);
        wr(SSP_IDX_CTRL, 8'hA7);
        frame(8'h11, 1'b0);
        rdc(SSP_IDX_STATUS, 8'h08, 8'h08);
        wr(SSP_IDX_CTRL, 8'h40);
        $display("test duplex done");
        wr(SSP_IDX_CTRL, 8'h9F);
        frame(8'h12, 1'b1);
        frame(8'h34, 1'b1);
        rdc(SSP_IDX_STATUS, 8'h04, 8'h04);
        n0 = irqs;
        frame(8'h56, 1'b1);
        chk(irqs, n0);
        wr(SSP_IDX_CTRL, 8'h1F);
        rdc(SSP_IDX_STATUS, 8'h84, 8'h84);
        rdc(SSP_IDX_RXBUF, 8'hFF, 8'h12);
        rdc(SSP_IDX_RXBUF, 8'hFF, 8'h34);
        wr(SSP_IDX_STATUS, 8'h08);
        rdc(SSP_IDX_STATUS, 8'h14, 8'h00);
        frame(8'h00, 1'b0);
        rdc(SSP_IDX_STATUS, 8'h80, 8'h00);
        $display("test overrun done");
        wr(SSP_IDX_CTRL, 8'h40);
        wr(SSP_IDX_CTRL, 8'hB7);
        n0 = irqs;
        frame(8'h77, 1'b0);
        chk(irqs, n0);
        rdc(SSP_IDX_STATUS, 8'h10, 8'h00);
        wr(SSP_IDX_CTRL, 8'h40);
        wr(SSP_IDX_TXBUF, 8'h5A);
        chk(32'(sck_drv), 32'h1);
        n0 = irqs;
        wr(SSP_IDX_CTRL, 8'h86);
        for (int i = 0; i < 2000 && irqs == n0; i++) @(posedge clk);
        chk(irqs, n0 + 1);
        chk(32'(oe_n), 32'h0);
        chk(32'(got), 32'h5A);
        repeat (20) @(posedge clk);
        chk(32'(sck_drv), 32'h1);
        $display("test internal done");
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        $display("mismatch at %0t: watchdog expired", $time);
        miscompares++;
        give_verdict();
    end
endmodule : ssp_tb_top
`default_nettype wire
